// [hdl/dcir_pkg.sv]
/*
 * Shared constants and types for the converter control and interrupt
 * register group: register offsets, bit positions, reset values,
 * valid-bit masks, serial phases and the carriers between blocks.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
`default_nettype none
package dcir_pkg;
    // Register offsets on the serial port
    localparam logic [6:0] ADDR_SERIAL_CFG = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
    localparam logic [6:0] ADDR_EN_SYNC_PLL = 7'h03;
    localparam logic [6:0] ADDR_EN_DATAPATH = 7'h04;
    localparam logic [6:0] ADDR_FLAG_SYNC_PLL = 7'h05;
    localparam logic [6:0] ADDR_FLAG_DATAPATH = 7'h06;
    localparam logic [6:0] ADDR_ROUTE_SYNC_PLL = 7'h07;

    // Field positions
    localparam int CFG_LSB_FIRST_BIT = 6;
    localparam int CFG_SOFT_RESET_BIT = 5;
    localparam int PD_I_ANALOG_BIT = 7;
    localparam int PD_Q_ANALOG_BIT = 6;
    localparam int PD_RECEIVER_BIT = 5;
    localparam int PD_CHIP_BIT = 2;
    localparam int PD_CLOCK_PATH_BIT = 1;
    localparam int FRAME_RECEIVER_OFF_BIT = 0;
    localparam int INSTR_READ_BIT = 7;

    // Values after reset
    localparam logic [7:0] RST_SERIAL_CFG = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN = 8'hC0;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;

    // Implemented bits of each register
    localparam logic [7:0] MASK_SERIAL_CFG = 8'h40;
    localparam logic [7:0] MASK_POWER_DOWN = 8'hE7;
    localparam logic [7:0] MASK_SYNC_PLL = 8'h7F;
    localparam logic [7:0] MASK_DATAPATH = 8'hF7;

    // Serial framing and FIFO warning thresholds
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;
    localparam logic [2:0] FIFO_WARN_LOW = 3'h1;
    localparam logic [2:0] FIFO_WARN_HIGH = 3'h6;

    typedef enum logic [0:0] {
        SP_INSTR = 1'b0,
        SP_DATA = 1'b1
    } dcir_phase_e;

    // One register access decoded from the serial port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dcir_bus_s;

    // Power-down controls towards the analog and clock blocks
    typedef struct packed {
        logic i_channel_analog_off;
        logic q_channel_analog_off;
        logic data_receiver_off;
        logic whole_chip_sleep;
        logic converter_clock_path_off;
        logic frame_receiver_off;
    } dcir_power_s;
endpackage
`default_nettype wire

// [hdl/dcir_flag_bank.sv]
/*
 * Bank of eight sticky status flags with per-flag enable and routing
 * to one of two interrupt requests. Assumes set and clear strobes are
 * synchronous to sys_clk; soft_rst is a one-cycle device reset.
 */
`default_nettype none
module dcir_flag_bank #(
    parameter logic [7:0] VALID = 8'hFF
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic soft_rst,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    input wire logic [7:0] enable,
    input wire logic [7:0] route,
    output logic [7:0] flags,
    output logic req_a,
    output logic req_b
);
    // One sticky flag per bit; a set in the clear cycle is kept
    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge sys_clk) begin
            if (!nrst || soft_rst || !VALID[i]) begin
                flags[i] <= dcir_pkg::RST_FLAGS[i];
            end else if (set[i]) begin
                flags[i] <= 1'b1;
            end else if (clr[i]) begin
                flags[i] <= 1'b0;
            end
        end
    end

    // Active flags split by route: 0 to line a, 1 to line b
    wire logic [7:0] live = flags & enable & VALID;
    assign req_a = |(live & ~route);
    assign req_b = |(live & route);
endmodule
`default_nettype wire

// [hdl/dcir_bit_shifter.sv]
/*
 * Byte shifter for the serial port in both directions, honouring the
 * selected bit order. Assumes shift strobes come from edge detection
 * of the serial clock in the sys_clk domain.
 */
`default_nettype none
module dcir_bit_shifter (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic lsb_first,
    input wire logic clear,
    input wire logic shift_in_en,
    input wire logic din,
    input wire logic load,
    input wire logic [7:0] load_data,
    input wire logic shift_out_en,
    output logic [7:0] byte_next,
    output logic dout
);
    logic [7:0] in_sr;
    logic [7:0] out_sr;

    // Byte as it stands once the present bit is taken in
    assign byte_next = lsb_first ? {din, in_sr[7:1]} : {in_sr[6:0], din};

    // Receive side
    always_ff @(posedge sys_clk) begin
        if (!nrst || clear) begin
            in_sr <= 8'h00;
        end else if (shift_in_en) begin
            in_sr <= byte_next;
        end
    end

    // Transmit side; the head bit follows the bit order
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            out_sr <= 8'h00;
            dout <= 1'b0;
        end else if (load) begin
            out_sr <= load_data;
        end else if (shift_out_en) begin
            dout <= lsb_first ? out_sr[0] : out_sr[7];
            out_sr <= lsb_first ? {1'b0, out_sr[7:1]} : {out_sr[6:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// [hdl/dcir_top.sv]
/*
 * Control and interrupt register group of a dual converter: serial port
 * slave, configuration and power-down registers, sticky status flags,
 * enables, routing and the two interrupt pins.
 * Assumes serial pins and event inputs are synchronous to sys_clk, with
 * sclk at most a quarter of the sys_clk rate.
 */
//
// Contract
// - Serial config bit 6 selects bit order: 0 MSB first, 1 LSB first.
// - Writing 1 to serial config bit 5 resets the device; reads 0.
// - Power-down bits 7,6 turn off I/Q analog only; reset to 1.
// - Power-down bit 5 turns off data receiver and FIFO write side.
// - Power-down bit 2 turns off band gap, hence the whole chip.
// - Power-down bit 1 stops the converter clock path.
// - Power-down bit 0 turns off frame receiver, forcing frame low.
// - Enable register 0 holds sync, PLL, threshold and mute enables.
// - Enable register 1 holds parity, compare, DLL and FIFO enables.
// - Flag register 0 bits 6..4 mark sync lost, locked, done.
// - Flag register 0 bits 3,2 mark PLL lost and PLL locked.
// - Flag register 0 bit 1 marks input power over threshold.
// - Flag register 0 bit 0 marks output muted to midscale.
// - Flag register 1 bits 7,6 mark parity and sample compare failure.
// - Flag register 1 bits 5,4 mark DLL warning and DLL lock.
// - Flag register 1 bit 2 marks FIFO underflow.
// - Flag register 1 bit 1 marks FIFO overflow.
// - Flag register 1 bit 0 marks FIFO level at most 1 or at least 6.
// - Route register 0 sends each flag to line a (0) or b (1).
// - Interrupt line a is active low.
`default_nettype none
module dcir_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic sync_lost_evt,
    input wire logic sync_locked_evt,
    input wire logic sync_done_evt,
    input wire logic pll_lost_evt,
    input wire logic pll_locked_evt,
    input wire logic over_threshold_evt,
    input wire logic output_mute_evt,
    input wire logic parity_fail_evt,
    input wire logic sample_compare_error_evt,
    input wire logic dll_warning_evt,
    input wire logic dll_locked_evt,
    input wire logic fifo_underflow_evt,
    input wire logic fifo_overflow_evt,
    input wire logic [2:0] fifo_fill_level,
    input wire logic [7:0] flag_clear_sync_pll,
    input wire logic [7:0] flag_clear_datapath,
    input wire logic frame_in,
    output logic frame_internal,
    output dcir_pkg::dcir_power_s power,
    output logic device_reset_pulse,
    output logic interrupt_line_a_n,
    output logic interrupt_line_b
);
    // Register storage
    logic [7:0] serial_port_config;
    logic [7:0] power_down_control;
    logic [7:0] irq_enable_sync_pll;
    logic [7:0] irq_enable_datapath;
    logic [7:0] irq_route_sync_pll;
    logic [7:0] irq_flags_sync_pll;
    logic [7:0] irq_flags_datapath;
    logic soft_rst;

    // Serial port state
    logic sclk_q;
    logic [2:0] bit_cnt;
    dcir_pkg::dcir_phase_e phase;
    logic read_op;
    logic [6:0] addr;
    logic sending;
    logic [7:0] byte_next;
    logic [7:0] rdata;
    dcir_pkg::dcir_bus_s bus;

    // Serial clock edges, only counted while selected
    wire logic sclk_rise = sclk & ~sclk_q & ~cs_n;
    wire logic sclk_fall = ~sclk & sclk_q & ~cs_n;
    wire logic byte_done = sclk_rise && (bit_cnt == dcir_pkg::LAST_BIT_IDX);
    wire logic in_instr = (phase == dcir_pkg::SP_INSTR);
    wire logic lsb_first = serial_port_config[dcir_pkg::CFG_LSB_FIRST_BIT];
    wire logic [6:0] addr_inc = addr + 7'h01;

    // Access decode: a write closes a data byte of a write instruction;
    // a read fetches at the end of the instruction and of each data byte
    assign bus.wr = byte_done && !in_instr && !read_op;
    assign bus.rd = byte_done && (in_instr ? byte_next[dcir_pkg::INSTR_READ_BIT] : read_op);
    assign bus.addr = (byte_done && in_instr) ? byte_next[6:0] : (bus.wr ? addr : addr_inc);
    assign bus.wdata = byte_next;

    // Edge detector sample of the serial clock
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Framing: instruction byte, then data bytes with auto-increment
    always_ff @(posedge sys_clk) begin
        if (!nrst || cs_n) begin
            bit_cnt <= 3'h0;
            phase <= dcir_pkg::SP_INSTR;
            read_op <= 1'b0;
            addr <= 7'h00;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                phase <= dcir_pkg::SP_DATA;
                if (in_instr) begin
                    read_op <= byte_next[dcir_pkg::INSTR_READ_BIT];
                    addr <= byte_next[6:0];
                end else begin
                    addr <= addr_inc;
                end
            end
        end
    end

    // Drive window: from the first falling edge after a fetch until
    // deselect, so the host never sees a floating bit mid-byte
    always_ff @(posedge sys_clk) begin
        if (!nrst || cs_n) begin
            sending <= 1'b0;
        end else if (sclk_fall && read_op && !in_instr) begin
            sending <= 1'b1;
        end
    end
    assign sdio_oe = sending;

    // Bit-order aware shifting in and out
    dcir_bit_shifter u_shifter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .lsb_first(lsb_first),
        .clear(cs_n),
        .shift_in_en(sclk_rise),
        .din(sdio_in),
        .load(bus.rd),
        .load_data(rdata),
        .shift_out_en(sclk_fall && read_op && !in_instr),
        .byte_next(byte_next),
        .dout(sdio_out)
    );

    // Write strobes per register
    wire logic wr_cfg = bus.wr && (bus.addr == dcir_pkg::ADDR_SERIAL_CFG);
    wire logic wr_pd = bus.wr && (bus.addr == dcir_pkg::ADDR_POWER_DOWN);
    wire logic wr_en0 = bus.wr && (bus.addr == dcir_pkg::ADDR_EN_SYNC_PLL);
    wire logic wr_en1 = bus.wr && (bus.addr == dcir_pkg::ADDR_EN_DATAPATH);
    wire logic wr_sel0 = bus.wr && (bus.addr == dcir_pkg::ADDR_ROUTE_SYNC_PLL);

    // Self-clearing soft reset: a one-cycle pulse that returns every register
    // and flag to its reset value; the serial engine survives so the frame ends cleanly
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_cfg && bus.wdata[dcir_pkg::CFG_SOFT_RESET_BIT];
        end
    end
    assign device_reset_pulse = soft_rst;

    // Configuration and power-down registers
    always_ff @(posedge sys_clk) begin
        if (!nrst || soft_rst) begin
            serial_port_config <= dcir_pkg::RST_SERIAL_CFG;
            power_down_control <= dcir_pkg::RST_POWER_DOWN;
        end else begin
            if (wr_cfg) begin
                serial_port_config <= bus.wdata & dcir_pkg::MASK_SERIAL_CFG;
            end
            if (wr_pd) begin
                power_down_control <= bus.wdata & dcir_pkg::MASK_POWER_DOWN;
            end
        end
    end

    // Enable and routing registers
    always_ff @(posedge sys_clk) begin
        if (!nrst || soft_rst) begin
            irq_enable_sync_pll <= dcir_pkg::RST_IRQ_ENABLE;
            irq_enable_datapath <= dcir_pkg::RST_IRQ_ENABLE;
            irq_route_sync_pll <= dcir_pkg::RST_IRQ_ROUTE;
        end else begin
            if (wr_en0) begin
                irq_enable_sync_pll <= bus.wdata & dcir_pkg::MASK_SYNC_PLL;
            end
            if (wr_en1) begin
                irq_enable_datapath <= bus.wdata & dcir_pkg::MASK_DATAPATH;
            end
            if (wr_sel0) begin
                irq_route_sync_pll <= bus.wdata & dcir_pkg::MASK_SYNC_PLL;
            end
        end
    end

    // Power-down controls; analog-only bits leave the digital path alone
    assign power.i_channel_analog_off = power_down_control[dcir_pkg::PD_I_ANALOG_BIT];
    assign power.q_channel_analog_off = power_down_control[dcir_pkg::PD_Q_ANALOG_BIT];
    assign power.data_receiver_off = power_down_control[dcir_pkg::PD_RECEIVER_BIT];
    assign power.whole_chip_sleep = power_down_control[dcir_pkg::PD_CHIP_BIT];
    assign power.converter_clock_path_off = power_down_control[dcir_pkg::PD_CLOCK_PATH_BIT];
    assign power.frame_receiver_off = power_down_control[dcir_pkg::FRAME_RECEIVER_OFF_BIT];

    // Frame held low while its receiver is off
    assign frame_internal = frame_in & ~power.frame_receiver_off;

    // Event vectors in flag-bit order
    wire logic fifo_warn = (fifo_fill_level <= dcir_pkg::FIFO_WARN_LOW)
        || (fifo_fill_level >= dcir_pkg::FIFO_WARN_HIGH);
    wire logic [7:0] set_sync_pll = {1'b0,
        sync_lost_evt, sync_locked_evt, sync_done_evt,
        pll_lost_evt, pll_locked_evt,
        over_threshold_evt,
        output_mute_evt};
    wire logic [7:0] set_datapath = {
        parity_fail_evt, sample_compare_error_evt,
        dll_warning_evt, dll_locked_evt,
        1'b0,
        fifo_underflow_evt,
        fifo_overflow_evt,
        fifo_warn};

    logic a_sync;
    logic b_sync;
    logic a_data;
    logic b_data;

    // Sync and PLL flags, routed by the route register
    dcir_flag_bank #(.VALID(dcir_pkg::MASK_SYNC_PLL)) u_flags_sync_pll (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .soft_rst(soft_rst),
        .set(set_sync_pll),
        .clr(flag_clear_sync_pll),
        .enable(irq_enable_sync_pll),
        .route(irq_route_sync_pll),
        .flags(irq_flags_sync_pll),
        .req_a(a_sync),
        .req_b(b_sync)
    );

    // Datapath flags; no route register here, so all go to line a
    dcir_flag_bank #(.VALID(dcir_pkg::MASK_DATAPATH)) u_flags_datapath (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .soft_rst(soft_rst),
        .set(set_datapath),
        .clr(flag_clear_datapath),
        .enable(irq_enable_datapath),
        .route(8'h00),
        .flags(irq_flags_datapath),
        .req_a(a_data),
        .req_b(b_data)
    );

    // Interrupt pins registered to keep them glitch free
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            interrupt_line_a_n <= 1'b1;
            interrupt_line_b <= 1'b0;
        end else begin
            interrupt_line_a_n <= ~(a_sync | a_data);
            interrupt_line_b <= b_sync | b_data;
        end
    end

    // Read-back mux; soft reset bit always reads 0, unmapped reads 0
    always_comb begin
        unique case (bus.addr)
            dcir_pkg::ADDR_SERIAL_CFG: rdata = serial_port_config;
            dcir_pkg::ADDR_POWER_DOWN: rdata = power_down_control;
            dcir_pkg::ADDR_EN_SYNC_PLL: rdata = irq_enable_sync_pll;
            dcir_pkg::ADDR_EN_DATAPATH: rdata = irq_enable_datapath;
            dcir_pkg::ADDR_FLAG_SYNC_PLL: rdata = irq_flags_sync_pll;
            dcir_pkg::ADDR_FLAG_DATAPATH: rdata = irq_flags_datapath;
            dcir_pkg::ADDR_ROUTE_SYNC_PLL: rdata = irq_route_sync_pll;
            default: rdata = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// [testbench/dcir_top_props.sv]
/* Checker on the ports of dcir_top: power-down outputs, soft reset
   pulse, frame gating, data pin enable and interrupt pins.
   Assumes one sys_clk domain with synchronous active-low nrst. */
`default_nettype none
module dcir_top_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sdio_oe,
    input wire logic frame_in,
    input wire logic frame_internal,
    input wire dcir_pkg::dcir_power_s power,
    input wire logic device_reset_pulse,
    input wire logic interrupt_line_a_n,
    input wire logic interrupt_line_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both analog channels off after reset, all else running
    localparam logic [5:0] PD_RST = 6'b110000;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Soft reset is a lone pulse; no second one within the next eight cycles
    a_soft_rst_single: assert property (device_reset_pulse |=> !device_reset_pulse [*8])
        else $error("device reset pulse not single");
    a_soft_rst_pd: assert property (device_reset_pulse |=> power == PD_RST)
        else $error("power-down not restored by soft reset");
    a_pd_after_reset: assert property ($rose(nrst) |-> power == PD_RST && !sdio_oe)
        else $error("power-down or pin enable wrong after reset");
    // Power-down may only move through a serial write
    a_pd_hold_idle: assert property (cs_n && $past(cs_n) && !device_reset_pulse |=> $stable(power))
        else $error("power-down changed without a frame");
    a_pins_after_reset: assert property ($rose(nrst) |-> interrupt_line_a_n && !interrupt_line_b)
        else $error("interrupt pins asserted after reset");
    a_oe_needs_select: assert property ($rose(sdio_oe) |-> !$past(cs_n))
        else $error("data pin driven without select");
    a_oe_drop: assert property (cs_n |=> !sdio_oe)
        else $error("data pin still driven after deselect");
    a_frame_forced_low: assert property (power.frame_receiver_off |-> !frame_internal)
        else $error("frame not forced low");
    a_frame_follows: assert property (!power.frame_receiver_off |-> frame_internal == frame_in)
        else $error("frame does not follow input");
endmodule

bind dcir_top dcir_top_props dcir_top_props_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sdio_oe(sdio_oe),
    .frame_in(frame_in),
    .frame_internal(frame_internal),
    .power(power),
    .device_reset_pulse(device_reset_pulse),
    .interrupt_line_a_n(interrupt_line_a_n),
    .interrupt_line_b(interrupt_line_b)
);
`default_nettype wire

// [testbench/dcir_host_model.sv]
/* Serial port host: one frame of up to two data bytes per call, either bit order.
   Assumes the bench resolves the shared data pin into sdio. */
`default_nettype none
module dcir_host_model (
    input wire logic sys_clk,
    input wire logic sdio,
    output logic sclk,
    output logic cs_n,
    output logic sdio_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: deselected, clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio_drv = 1'b0;
    end

    // Three cycles per sclk phase, above the two the device needs
    // Data byte j of the frame sits in bits 8j+7..8j; at most two data bytes
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                        input logic lsb, input int nb, output logic [15:0] q);
        logic [7:0] ins;
        int b;
        ins = {rd, a};
        q = 16'h0000;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        for (int k = 0; k < 8 * (nb + 1); k++) begin
            b = (k / 8 - 1) * 8 + (lsb ? k % 8 : 7 - k % 8);
            sclk <= 1'b0;
            // Released during read data: toggle so no stale bit survives
            if (k < 8) sdio_drv <= ins[b + 8];
            else if (!rd) sdio_drv <= wd[b];
            else sdio_drv <= ~sdio_drv;
            repeat (3) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            if (rd && k >= 8) q[b] = sdio;
            @(posedge sys_clk);
        end
        sclk <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cs_n <= 1'b1;
        sdio_drv <= ~sdio_drv;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// [testbench/dcir_top_tb.sv]
/* Bench for dcir_top: register traffic via the host model, event
   pulses, flag clears and pin checks. Assumes sys_clk at 25 MHz. */
`default_nettype none
module dcir_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic frame_in = 1'b0;
    logic lsb = 1'b0;
    logic [15:0] evt = 16'h0000;
    logic [15:0] clr = 16'h0000;
    logic [2:0] lvl = 3'h3;
    logic [15:0] q;
    logic [7:0] pdv [5] = '{8'hFF, 8'h24, 8'h02, 8'h01, 8'h00};
    logic [2:0] lvv [5] = '{3'h0, 3'h2, 3'h5, 3'h6, 3'h7};
    int error_cnt = 0;
    int n_tests = 0;
    int pulses = 0;
    wire logic sclk, cs_n, host_d, sdio_out, sdio_oe, frame_int, rst_p, irq_a_n, irq_b;
    wire dcir_pkg::dcir_power_s power;
    // Shared data pin: the device wins while its enable is high
    wire logic sdio = sdio_oe ? sdio_out : host_d;

    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rst_p === 1'b1) pulses <= pulses + 1;

    dcir_top dcir_top_inst (
        .sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sync_lost_evt(evt[6]), .sync_locked_evt(evt[5]), .sync_done_evt(evt[4]),
        .pll_lost_evt(evt[3]), .pll_locked_evt(evt[2]),
        .over_threshold_evt(evt[1]), .output_mute_evt(evt[0]),
        .parity_fail_evt(evt[15]), .sample_compare_error_evt(evt[14]),
        .dll_warning_evt(evt[13]), .dll_locked_evt(evt[12]),
        .fifo_underflow_evt(evt[10]), .fifo_overflow_evt(evt[9]),
        .fifo_fill_level(lvl), .flag_clear_sync_pll(clr[7:0]),
        .flag_clear_datapath(clr[15:8]), .frame_in(frame_in),
        .frame_internal(frame_int), .power(power), .device_reset_pulse(rst_p),
        .interrupt_line_a_n(irq_a_n), .interrupt_line_b(irq_b)
    );
    dcir_host_model dcir_host_model_inst (
        .sys_clk(sys_clk), .sdio(sdio), .sclk(sclk), .cs_n(cs_n), .sdio_drv(host_d)
    );

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        dcir_host_model_inst.xfer(1'b0, a, {8'h00, d}, lsb, 1, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        dcir_host_model_inst.xfer(1'b1, a, 16'h0000, lsb, 1, q);
        chk8(q[7:0], exp);
    endtask
    task automatic pins(input logic a_n, input logic b);
        chk8({6'h00, irq_a_n, irq_b}, {6'h00, a_n, b});
    endtask
    // Bit 8 of the event vector stands for a low FIFO level
    task automatic hit(input logic [15:0] e, input logic [15:0] c);
        @(posedge sys_clk);
        evt <= e;
        clr <= c;
        lvl <= e[8] ? 3'h1 : 3'h3;
        @(posedge sys_clk);
        evt <= 16'h0000;
        clr <= 16'h0000;
        lvl <= 3'h3;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        logic [7:0] e8;
        logic rb;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        // Reset values; 0x02 is unmapped and reads zero
        for (int a = 0; a < 8; a++) rd(7'(a), (a == 1) ? 8'hC0 : 8'h00);
        // All ones: unused bits, read-only flags and unmapped place stay zero
        for (int a = 2; a < 8; a++) begin
            e8 = (a == 3 || a == 7) ? dcir_pkg::MASK_SYNC_PLL : 8'h00;
            if (a == 4) e8 = dcir_pkg::MASK_DATAPATH;
            wr(7'(a), 8'hFF);
            rd(7'(a), e8);
        end
        // Frame unused while bit 0 is set
        frame_in <= 1'b1;
        foreach (pdv[k]) begin
            wr(7'h01, pdv[k]);
            rd(7'h01, pdv[k] & dcir_pkg::MASK_POWER_DOWN);
            chk8({2'b00, power}, {2'b00, pdv[k][7:5], pdv[k][2:0]});
            chk8({7'h00, frame_int}, {7'h00, ~pdv[k][0]});
        end
        // Even sync/PLL flags go to line b, the rest to line a
        wr(7'h07, 8'h55);
        for (int i = 0; i < 16; i++) begin
            if (i == 7 || i == 11) continue;
            rb = (i < 8) && (i % 2 == 0);
            hit(16'h0001 << i, 16'h0000);
            rd(i < 8 ? 7'h05 : 7'h06, 8'h01 << (i % 8));
            pins(rb, rb);
            hit(16'h0001 << i, 16'h0001 << i);
            rd(i < 8 ? 7'h05 : 7'h06, 8'h01 << (i % 8));
            hit(16'h0000, 16'h0001 << i);
            rd(i < 8 ? 7'h05 : 7'h06, 8'h00);
            pins(1'b1, 1'b0);
        end
        // FIFO warning at or beyond the level boundaries, not between them
        foreach (lvv[k]) begin
            @(posedge sys_clk) lvl <= lvv[k];
            @(posedge sys_clk) lvl <= 3'h3;
            rd(7'h06, {7'h00, lvv[k] <= 3'h1 || lvv[k] >= 3'h6});
            hit(16'h0000, 16'h0100);
        end
        // Disabled flag still latches but raises no pin
        wr(7'h03, 8'h00);
        hit(16'h0001, 16'h0000);
        rd(7'h05, 8'h01);
        pins(1'b1, 1'b0);
        // Bit order: route register read back least significant bit first
        wr(7'h00, 8'h40);
        lsb = 1'b1;
        rd(7'h00, 8'h40);
        rd(7'h07, 8'h55);
        // Two data bytes per frame: the address steps after each byte
        dcir_host_model_inst.xfer(1'b0, 7'h03, 16'hFF2A, lsb, 2, q);
        dcir_host_model_inst.xfer(1'b1, 7'h03, 16'h0000, lsb, 2, q);
        chk8(q[7:0], 8'h2A);
        chk8(q[15:8], dcir_pkg::MASK_DATAPATH);
        wr(7'h00, 8'h60);
        lsb = 1'b0;
        rd(7'h00, 8'h00);
        rd(7'h01, 8'hC0);
        rd(7'h05, 8'h00);
        chk8(8'(pulses), 8'h01);
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
